//--- include/bipc_pkg.sv
// shared types and constants for the bus interrupt and power control block
package bipc_pkg;

  localparam int CLK_NS = 25;
  localparam int ACK_DELAY_NS = 225;
  localparam int ACK_DELAY_CYC = (ACK_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAPTURE_NS = 200;
  localparam int CAPTURE_CYC = (CAPTURE_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_MIN_NS = 8000;
  localparam int INIT_MAX_NS = 20000;
  localparam int INIT_PULSE_CYC = (INIT_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_MAX_CYC = INIT_MAX_NS / CLK_NS;
  localparam int PDOWN_INIT_NS = 1000;
  localparam int PDOWN_INIT_CYC = (PDOWN_INIT_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [8:0] EVENT_VECTOR = 9'h040;
  localparam logic [2:0] EVENT_LEVEL = 3'h6;
  localparam logic [2:0] LEVEL_FOUR = 3'h4;
  localparam logic [2:0] LEVEL_FIVE = 3'h5;
  localparam logic [2:0] LEVEL_SIX = 3'h6;
  localparam logic [2:0] LEVEL_SEVEN = 3'h7;
  localparam logic [2:0] LEVEL_NONE = 3'h0;
  localparam logic [1:0] VECTOR_LOW_BITS = 2'h0;
  localparam int SYNC_WIDTH = 9;

  typedef enum logic [3:0] {
    ACK_IDLE = 4'h1,
    ACK_STROBE = 4'h2,
    ACK_WAIT_REPLY = 4'h4,
    ACK_RELEASE = 4'h8
  } bipc_ack_state_t;

  // receiver outputs of the bus, asserted high
  typedef struct packed {
    logic replySense;
    logic requestLevelSeven;
    logic requestLevelSix;
    logic requestLevelFive;
    logic requestLevelFour;
    logic haltRequest;
    logic externalEventLine;
    logic powerOk;
    logic dcPowerOk;
  } bipc_bus_in_t;

  // driver inputs of the bus, asserted high
  typedef struct packed {
    logic inputStrobeDrive;
    logic ackChainOut;
    logic busInitialize;
  } bipc_bus_out_t;

  // answers toward the processor core
  typedef struct packed {
    logic intTake;
    logic eventTake;
    logic [8:0] intVector;
    logic consoleDebugMode;
    logic powerFailTrap;
    logic goStart;
  } bipc_core_out_t;

  typedef struct packed {
    bipc_ack_state_t st;
    logic [3:0] cnt;
    logic [9:0] pulseCnt;
    logic [5:0] pdCnt;
    logic dcPrev;
    logic pokPrev;
    logic evtPrev;
    logic evtPend;
    logic goPend;
    bipc_bus_out_t bus;
    bipc_core_out_t core;
  } bipc_state_t;

endpackage

//--- hdl/bipc_sync.sv
// two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module bipc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      stage1_r <= '0;
      dout <= '0;
    end else begin
      stage1_r <= din;
      dout <= stage1_r;
    end
  end
endmodule
`default_nettype wire

//--- hdl/bipc_ctrl.sv
// processor-side interrupt acknowledge, halt, initialize and power status control
//
// Summary of operation
// - acknowledge only above status priority, at instruction end
// - strobe first, acknowledge chain 225 ns later
// - 200 ns after reply, capture vector, drop both
// - vectors 000 to 774 octal on lines 8..2
// - halt request forces console mode, never driven
// - initialize on power events, reset, console go
// - power ok loss while running starts fail trap
// - initialize held until dc ok asserts at power-up
// - reset instruction gives 8 to 20 us initialize
// - initialize at least 1 us after dc ok drops
// - event line serviced with fixed vector 100 octal
`timescale 1ns/1ps
`default_nettype none
module bipc_ctrl (
  input wire logic clock,
  input wire logic reset_n,
  input wire bipc_pkg::bipc_bus_in_t busIn,
  input wire logic [6:0] vectorLines,
  input wire logic [2:0] statusPriorityField,
  input wire logic instrDone,
  input wire logic resetInstr,
  input wire logic goCmd,
  output bipc_pkg::bipc_bus_out_t busOut,
  output bipc_pkg::bipc_core_out_t coreOut
);
  import bipc_pkg::*;

  bipc_bus_in_t syncIn;
  bipc_state_t s_r;
  bipc_state_t s_nxt;
  logic [2:0] reqLevel;
  logic dcFall;
  logic running;

  ////////////////////////////////////////////////////////////////////////////
  bipc_sync #(.WIDTH(SYNC_WIDTH)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .din(busIn),
    .dout(syncIn)
  );

  // highest level currently requested on the bus
  always_comb begin
    if (syncIn.requestLevelSeven) begin
      reqLevel = LEVEL_SEVEN;
    end else if (syncIn.requestLevelSix) begin
      reqLevel = LEVEL_SIX;
    end else if (syncIn.requestLevelFive) begin
      reqLevel = LEVEL_FIVE;
    end else if (syncIn.requestLevelFour) begin
      reqLevel = LEVEL_FOUR;
    end else begin
      reqLevel = LEVEL_NONE;
    end
  end

  assign dcFall = s_r.dcPrev && !syncIn.dcPowerOk;
  assign running = !s_r.core.consoleDebugMode && syncIn.dcPowerOk;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.core.intTake = 1'b0;
    s_nxt.core.eventTake = 1'b0;
    s_nxt.core.powerFailTrap = 1'b0;
    s_nxt.core.goStart = 1'b0;
    s_nxt.dcPrev = syncIn.dcPowerOk;
    s_nxt.pokPrev = syncIn.powerOk;
    s_nxt.evtPrev = syncIn.externalEventLine;

    // event edge is latched; a new edge wins over the clearing take
    if (syncIn.externalEventLine && !s_r.evtPrev) begin
      s_nxt.evtPend = 1'b1;
    end

    if (syncIn.haltRequest) begin
      s_nxt.core.consoleDebugMode = 1'b1;
    end

    if (s_r.pokPrev && !syncIn.powerOk && running) begin
      s_nxt.core.powerFailTrap = 1'b1;
    end

    unique case (s_r.st)
      ACK_IDLE: begin
        s_nxt.cnt = '0;
        if (instrDone && running && s_r.evtPend && EVENT_LEVEL > statusPriorityField) begin
          s_nxt.core.eventTake = 1'b1;
          s_nxt.core.intVector = EVENT_VECTOR;
          s_nxt.evtPend = syncIn.externalEventLine && !s_r.evtPrev;
        end else if (instrDone && running && reqLevel > statusPriorityField) begin
          s_nxt.st = ACK_STROBE;
          s_nxt.bus.inputStrobeDrive = 1'b1;
        end
      end
      ACK_STROBE: begin
        s_nxt.cnt = s_r.cnt + 4'h1;
        if (s_r.cnt == 4'(ACK_DELAY_CYC - 1)) begin
          s_nxt.bus.ackChainOut = 1'b1;
          s_nxt.st = ACK_WAIT_REPLY;
          s_nxt.cnt = '0;
        end
      end
      ACK_WAIT_REPLY: begin
        if (syncIn.replySense) begin
          s_nxt.cnt = s_r.cnt + 4'h1;
          if (s_r.cnt == 4'(CAPTURE_CYC - 1)) begin
            s_nxt.core.intVector = {vectorLines, VECTOR_LOW_BITS};
            s_nxt.core.intTake = 1'b1;
            s_nxt.bus.inputStrobeDrive = 1'b0;
            s_nxt.bus.ackChainOut = 1'b0;
            s_nxt.st = ACK_RELEASE;
          end
        end
      end
      ACK_RELEASE: begin
        if (!syncIn.replySense) begin
          s_nxt.st = ACK_IDLE;
        end
      end
    endcase

    // initialize pulse from reset instruction or console go
    if (s_r.pulseCnt != '0) begin
      s_nxt.pulseCnt = s_r.pulseCnt - 10'h001;
      if (s_r.pulseCnt == 10'h001 && s_r.goPend) begin
        s_nxt.goPend = 1'b0;
        s_nxt.core.goStart = 1'b1;
        s_nxt.core.consoleDebugMode = syncIn.haltRequest;
      end
    end else if (resetInstr) begin
      s_nxt.pulseCnt = 10'(INIT_PULSE_CYC);
    end else if (goCmd && s_r.core.consoleDebugMode) begin
      s_nxt.pulseCnt = 10'(INIT_PULSE_CYC);
      s_nxt.goPend = 1'b1;
    end

    if (dcFall) begin
      s_nxt.pdCnt = 6'(PDOWN_INIT_CYC);
    end else if (s_r.pdCnt != '0) begin
      s_nxt.pdCnt = s_r.pdCnt - 6'h01;
    end

    // power-up holds initialize until dc ok; power-down waits out the delay
    s_nxt.bus.busInitialize = (s_nxt.pulseCnt != '0) ||
      (!syncIn.dcPowerOk && !dcFall && s_r.pdCnt <= 6'h01);
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_r <= '{st: ACK_IDLE, cnt: '0, pulseCnt: '0, pdCnt: '0, dcPrev: 1'b0,
               pokPrev: 1'b0, evtPrev: 1'b0, evtPend: 1'b0, goPend: 1'b0,
               bus: '{inputStrobeDrive: 1'b0, ackChainOut: 1'b0, busInitialize: 1'b1},
               core: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busOut = s_r.bus;
  assign coreOut = s_r.core;

  ////////////////////////////////////////////////////////////////////////////
  // helper: length of the current initialize assertion
  logic [10:0] initRun_r;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      initRun_r <= '0;
    end else if (s_r.bus.busInitialize) begin
      initRun_r <= initRun_r + 11'h001;
    end else begin
      initRun_r <= '0;
    end
  end

  sequence pdownQuiet;
    !s_r.bus.busInitialize [*8];
  endsequence

  sequence pdownAssert;
    ##[32:40] s_r.bus.busInitialize;
  endsequence

  a_ack_after_strobe: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(s_r.bus.ackChainOut) |-> $past(s_r.bus.inputStrobeDrive, 9)
      && $past(s_r.bus.inputStrobeDrive, 1))
    else $error("acknowledge rose too soon after strobe");

  a_ack_priority_gate: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(s_r.bus.inputStrobeDrive) |-> $past(reqLevel > statusPriorityField && instrDone))
    else $error("acknowledge started without higher level or instruction end");

  a_capture_after_reply: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(s_r.bus.inputStrobeDrive) |-> $past(syncIn.replySense, 8) && s_r.core.intTake
      && !s_r.bus.ackChainOut)
    else $error("strobe dropped before reply time elapsed");

  a_vector_range: assert property (@(posedge clock) disable iff (!reset_n)
    s_r.core.intTake |-> s_r.core.intVector == {$past(vectorLines), VECTOR_LOW_BITS})
    else $error("vector not taken from the data lines");

  a_event_fixed_vector: assert property (@(posedge clock) disable iff (!reset_n)
    s_r.core.eventTake |-> s_r.core.intVector == EVENT_VECTOR && !s_r.bus.inputStrobeDrive)
    else $error("event serviced with bus vector read");

  a_reset_pulse_len: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(s_r.bus.busInitialize) && $past(s_r.pulseCnt) == 10'h001
      |-> initRun_r >= 11'(INIT_PULSE_CYC) && initRun_r <= 11'(INIT_MAX_CYC))
    else $error("initialize pulse length out of range");

  a_pdown_init_delay: assert property (@(posedge clock) disable iff (!reset_n)
    dcFall && s_r.pulseCnt == '0 && !resetInstr && !goCmd |=> pdownQuiet ##0 pdownAssert)
    else $error("power-down initialize timing wrong");

  a_init_release_dc: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(s_r.bus.busInitialize) |-> $past(syncIn.dcPowerOk))
    else $error("initialize released before dc ok");

  a_halt_console: assert property (@(posedge clock) disable iff (!reset_n)
    syncIn.haltRequest |=> s_r.core.consoleDebugMode)
    else $error("halt request did not enter console mode");

  a_power_fail_trap: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(syncIn.powerOk) && running |=> s_r.core.powerFailTrap)
    else $error("power-fail trap missed");
endmodule
`default_nettype wire

//--- testbench/bipc_intr_model.sv
// interrupting device on the acknowledge chain, single position
`timescale 1ns/1ps
`default_nettype none
module bipc_intr_model (
  input wire logic clock,
  input wire logic strobe,
  input wire logic ackIn,
  input wire logic [2:0] level,
  input wire logic [6:0] vector,
  output logic [3:0] requestLines,
  output logic reply,
  output logic [6:0] vectorLines
);
  logic keep = 1'b0;
  logic served = 1'b0;
  logic strobePrev = 1'b0;
  logic replyR = 1'b0;
  assign reply = replyR;
  // lines are {seven, six, five, four}
  always_comb begin
    case (level)
      3'h4: requestLines = 4'h1;
      3'h5: requestLines = 4'h3;
      3'h6: requestLines = 4'h5;
      3'h7: requestLines = 4'hD;
      default: requestLines = 4'h0;
    endcase
    if (served) requestLines = 4'h0;
  end
  // lone device: keep-or-pass decided at the strobe's leading edge
  always @(posedge clock) begin
    strobePrev <= strobe;
    if (strobe && !strobePrev) begin
      keep <= |requestLines;
    end
    if (ackIn && keep && !replyR) begin
      replyR <= 1'b1;
      served <= 1'b1;
    end else if (!ackIn && replyR) begin
      replyR <= 1'b0;
      keep <= 1'b0;
    end
    if (level == 3'h0) served <= 1'b0;
  end
  // released lines show the inverse of the vector
  assign vectorLines = replyR ? vector : ~vector;
endmodule
`default_nettype wire

//--- testbench/bus_interrupt_power_control_test.sv
// self-checking bench for the interrupt, initialize and power control block
`timescale 1ns/1ps
`default_nettype none
module bus_interrupt_power_control_test;
  import bipc_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic halt = 1'b0, evt = 1'b0, pok = 1'b0, dcok = 1'b0;
  logic instrDone = 1'b1, resetInstr = 1'b0, goCmd = 1'b0;
  logic [2:0] prio = 3'h7, level = 3'h0;
  logic [6:0] vec = 7'h00;
  logic [3:0] rq;
  logic rply;
  logic [6:0] vectorLines;
  bipc_bus_in_t busIn;
  bipc_bus_out_t busOut;
  bipc_core_out_t coreOut;
  int err_total = 0, samples_checked = 0, cycles = 0, n;
  assign busIn = {rply, rq[3], rq[2], rq[1], rq[0], halt, evt, pok, dcok};
  bipc_ctrl u_dut (.clock(clock), .reset_n(reset_n), .busIn(busIn),
    .vectorLines(vectorLines), .statusPriorityField(prio), .instrDone(instrDone),
    .resetInstr(resetInstr), .goCmd(goCmd), .busOut(busOut), .coreOut(coreOut));
  bipc_intr_model u_dev (.clock(clock), .strobe(busOut.inputStrobeDrive),
    .ackIn(busOut.ackChainOut), .level(level), .vector(vec), .requestLines(rq),
    .reply(rply), .vectorLines(vectorLines));
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic step(int k = 1);
    repeat (k) @(posedge clock);
    #2;
  endtask
  task automatic chkBit(string nm, logic e, logic g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic sig(int k);
    case (k)
      0: return busOut.inputStrobeDrive;
      1: return busOut.ackChainOut;
      2: return busOut.busInitialize;
      3: return coreOut.intTake;
      4: return coreOut.eventTake;
      5: return coreOut.powerFailTrap;
      default: return coreOut.goStart;
    endcase
  endfunction
  // cycles until signal k shows v, bounded
  task automatic waitSig(int k, logic v, int lim, output int c);
    c = 0;
    while (sig(k) !== v && c < lim) begin
      step();
      c++;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_powerup();
    step(20);
    chkBit("initHeld", 1'h1, busOut.busInitialize);
    dcok = 1'b1;
    waitSig(2, 1'b0, 6, n);
    chkBit("initRel", 1'h1, n >= 2 && n < 6);
    pok = 1'b1;
    step(4);
    $display("test powerup done");
  endtask
  task automatic t_irq(logic [2:0] p, logic [2:0] l, logic [6:0] v);
    prio = p;
    vec = v;
    level = l;
    step(30);
    chkBit("refused", 1'h0, busOut.inputStrobeDrive);
    prio = l - 3'h1;
    instrDone = 1'b0;
    step(4);
    chkBit("midInstr", 1'h0, busOut.inputStrobeDrive);
    instrDone = 1'b1;
    waitSig(0, 1'b1, 10, n);
    chkBit("strobe", 1'h1, busOut.inputStrobeDrive);
    waitSig(1, 1'b1, 20, n);
    chk("ackDelay", 9'(ACK_DELAY_CYC), 9'(n));
    waitSig(3, 1'b1, 30, n);
    chkBit("intTake", 1'h1, coreOut.intTake);
    chk("vector", {v, VECTOR_LOW_BITS}, coreOut.intVector);
    chk("dropBoth", 9'h000, 9'({busOut.inputStrobeDrive, busOut.ackChainOut}));
    level = 3'h0;
    step(6);
    $display("test irq level %0d done", l);
  endtask
  task automatic t_event();
    prio = 3'h5;
    evt = 1'b1;
    waitSig(4, 1'b1, 8, n);
    chkBit("evtTake", 1'h1, coreOut.eventTake);
    chk("evtVec", EVENT_VECTOR, coreOut.intVector);
    chkBit("evtNoStrobe", 1'h0, busOut.inputStrobeDrive);
    evt = 1'b0;
    step(4);
    $display("test event done");
  endtask
  task automatic initPulse(output int len);
    waitSig(2, 1'b1, 5, n);
    waitSig(2, 1'b0, 900, len);
  endtask
  task automatic t_reset_go();
    resetInstr = 1'b1;
    step();
    resetInstr = 1'b0;
    initPulse(n);
    chkBit("rstLen", 1'h1, n >= INIT_PULSE_CYC && n <= INIT_MAX_CYC);
    chkBit("rstNoGo", 1'h0, coreOut.goStart);
    goCmd = 1'b1;
    step();
    goCmd = 1'b0;
    step(2);
    chkBit("goIgnored", 1'h0, busOut.busInitialize);
    halt = 1'b1;
    step(4);
    chkBit("console", 1'h1, coreOut.consoleDebugMode);
    halt = 1'b0;
    step(3);
    goCmd = 1'b1;
    step();
    goCmd = 1'b0;
    initPulse(n);
    chkBit("goLen", 1'h1, n >= INIT_PULSE_CYC && n <= INIT_MAX_CYC);
    chkBit("goStart", 1'h1, coreOut.goStart);
    step();
    chkBit("consoleOff", 1'h0, coreOut.consoleDebugMode);
    $display("test reset and go done");
  endtask
  task automatic t_powerdown();
    pok = 1'b0;
    waitSig(5, 1'b1, 6, n);
    chkBit("failTrap", 1'h1, coreOut.powerFailTrap);
    step(10);
    dcok = 1'b0;
    waitSig(2, 1'b1, 80, n);
    chkBit("pdInit", 1'h1, n >= PDOWN_INIT_CYC && n < 80);
    $display("test powerdown done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    step(3);
    reset_n = 1'b1;
    chkBit("rstInit", 1'h1, busOut.busInitialize);
    t_powerup();
    t_event();
    t_irq(3'h5, 3'h5, 7'h35);
    t_irq(3'h7, 3'h7, 7'h7F);
    t_irq(3'h4, 3'h4, 7'h01);
    t_reset_go();
    t_powerdown();
    finish_test();
  end
endmodule
`default_nettype wire
